// ---- hw/sq_pkg.sv ----
// Constants and types shared by the status and queue logic
package sq_pkg;

  // Queue sizes
  localparam int OUT_Q_DEPTH = 8;
  localparam int OUT_Q_WIDTH = 16;
  localparam int ERR_Q_DEPTH = 10;
  localparam int ERR_TEXT_W = 8;

  // Mask registers: widths and reset values
  localparam int STD_W = 8;
  localparam int SET_W = 16;
  localparam logic [7:0] STD_MASK_RESET = 8'h00;
  localparam logic [15:0] SET_MASK_RESET = 16'h0000;
  localparam logic [7:0] SRE_RESET = 8'h00;

  // Status byte bit positions
  localparam int STB_MSB = 0;
  localparam int STB_EAV = 2;
  localparam int STB_QSB = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;
  localparam int STB_OSB = 7;

  // Operation-complete bit of the standard event register
  localparam int ESR_OPC = 0;

  // Fixed response and error-queue codes
  localparam logic [15:0] ASCII_ONE = 16'h0031;
  localparam logic [15:0] CODE_NO_ERROR = 16'h0000;
  localparam logic [15:0] CODE_OVERFLOW = 16'h015e;
  localparam logic [7:0] TEXT_NO_ERROR = 8'h00;
  localparam logic [7:0] TEXT_OVERFLOW = 8'h01;

  // Positive codes at or above this are status messages
  localparam logic [15:0] STATUS_FLOOR = 16'h0320;

  // Filter bins: sign plus four magnitude bits
  localparam int FILT_BINS = 32;
  localparam logic [31:0] ERR_ADMIT_RESET = 32'hffff_ffff;
  localparam logic [31:0] STAT_ADMIT_RESET = 32'h0000_0000;

  typedef enum logic [4:0] {
    CMD_NOP,
    CMD_STD_MASK_WR, CMD_STD_MASK_RD,
    CMD_OPER_MASK_WR, CMD_OPER_MASK_RD,
    CMD_MEAS_MASK_WR, CMD_MEAS_MASK_RD,
    CMD_QUES_MASK_WR, CMD_QUES_MASK_RD,
    CMD_SRE_WR, CMD_SRE_RD, CMD_STB_RD,
    CMD_STD_EVENT_RD, CMD_OPER_EVENT_RD, CMD_MEAS_EVENT_RD, CMD_QUES_EVENT_RD,
    CMD_CLEAR_STATUS, CMD_PRESET,
    CMD_OP_DONE, CMD_OP_DONE_RD,
    CMD_ERR_NEXT_RD, CMD_ERR_CLEAR_A, CMD_ERR_CLEAR_B,
    CMD_FILT_ENA_BEGIN, CMD_FILT_ENA_ADD, CMD_FILT_DIS
  } sq_cmd_e;

endpackage

// ---- hw/sq_fifo_if.sv ----
// Write and read sides of the output queue
`timescale 1ns/100ps
`default_nettype none
interface sq_fifo_if #(parameter int W = 16, parameter int CW = 4);
  logic wrValid;
  logic [W-1:0] wrData;
  logic wrReady;
  logic [CW-1:0] count;
  logic rdValid;
  logic [W-1:0] rdData;
  logic rdReady;
  modport owner (output wrValid, output wrData, input wrReady, input count,
                 input rdValid, input rdData, output rdReady);
  modport queue (input wrValid, input wrData, output wrReady, output count,
                 output rdValid, output rdData, input rdReady);
endinterface
`default_nettype wire

// ---- hw/sq_fifo.sv ----
// Output queue: synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sq_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic clock,
  input wire logic srst,
  sq_fifo_if.queue q
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0] mem [D];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [CW-1:0] count_reg;
  logic notEmpty_reg;
  logic notFull_reg;
  logic push;
  logic pop;
  logic [CW-1:0] countNext;

  assign push = q.wrValid & notFull_reg;
  assign pop = q.rdReady & notEmpty_reg;
  assign countNext = count_reg + CW'(push) - CW'(pop);
  assign q.wrReady = notFull_reg;
  assign q.rdValid = notEmpty_reg;
  assign q.rdData = mem[rdPtr_reg];
  assign q.count = count_reg;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_reg] <= q.wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      notEmpty_reg <= 1'b0;
      notFull_reg <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PW'(D - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(D - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= countNext;
      notEmpty_reg <= (countNext != '0);
      notFull_reg <= (countNext != CW'(D));
    end
  end
endmodule
`default_nettype wire

// ---- hw/sq_err_mem.sv ----
// Error queue storage with registered read data
`timescale 1ns/100ps
`default_nettype none
module sq_err_mem #(
  parameter int W = 24,
  parameter int D = 10
) (
  input wire logic clock,
  input wire logic wrEn,
  input wire logic [$clog2(D)-1:0] wrAddr,
  input wire logic [W-1:0] wrData,
  input wire logic [$clog2(D)-1:0] rdAddr,
  output logic [W-1:0] rdData
);
  logic [W-1:0] mem [D];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// ---- hw/sq_status_top.sv ----
// Status byte, event masks, output queue and filtered error queue
// Contract
// - Each summary bit is set when any event bit and its mask bit are both 1.
// - Standard event mask is eight bits, writable 0..255 and readable back.
// - Operation, measurement, questionable masks are sixteen bits, writable and readable.
// - Writing zero to a mask clears all its bits and they stay zero.
// - Reset clears all masks; preset clears all but the service request mask; clear-status leaves them alone.
// - Writing a response into the output queue sets the message-available bit.
// - Reading removes a response; an empty output queue clears message-available.
// - Error entry sets error-available; an empty error queue clears it.
// - Error queue holds ten entries; reads return oldest code and text, then remove.
// - On filling, the last slot holds overflow entry code 350.
// - Reading an empty error queue returns code 0, no error.
// - Entry codes are signed: negative standard, positive maker-defined.
// - Reset admits error codes, excludes status codes; clear-status and preset keep filter.
// - Enable-list replaces the admitted set; disable-list removes only listed codes (the code clears each listed code's whole filter bin).
// - Enable-list with an empty list blocks every code.
// - Reset and clear-status empty the error queue; preset does not.
// - Both error-queue clear commands discard all pending entries.
// - Clear-status resets every event register and empties the error queue together.
// - Standard event query returns the register then clears it.
// - Operation-complete command sets its event bit once nothing is pending.
// - Operation-complete query queues ASCII 1 once nothing is pending.
// - Service request mask is writable and readable; status byte is readable.
// - Event bits latch at 1 until read or cleared.
`timescale 1ns/100ps
`default_nettype none
module sq_status_top import sq_pkg::*; #(
  parameter int OUT_DEPTH = OUT_Q_DEPTH,
  parameter int ERR_DEPTH = ERR_Q_DEPTH
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmdValid,
  input wire sq_cmd_e cmdOp,
  input wire logic [15:0] cmdData,
  output logic cmdReady,
  output logic outValid,
  output logic [OUT_Q_WIDTH-1:0] outData,
  input wire logic outReady,
  input wire logic [STD_W-1:0] stdEvents,
  input wire logic [SET_W-1:0] operEvents,
  input wire logic [SET_W-1:0] measEvents,
  input wire logic [SET_W-1:0] quesEvents,
  input wire logic opsPending,
  input wire logic errValid,
  input wire logic signed [15:0] errCode,
  input wire logic [ERR_TEXT_W-1:0] errText,
  output logic [7:0] statusByte
);
  localparam int OCW = $clog2(OUT_DEPTH + 1);
  localparam int EPW = $clog2(ERR_DEPTH);
  localparam int ECW = $clog2(ERR_DEPTH + 1);
  localparam int EW = 16 + ERR_TEXT_W;

  typedef enum logic [1:0] {ST_IDLE, ST_ERR_CODE, ST_ERR_TEXT} sq_state_e;

  sq_fifo_if #(.W(OUT_Q_WIDTH), .CW(OCW)) outQ ();

  sq_fifo #(.W(OUT_Q_WIDTH), .D(OUT_DEPTH)) outFifo (
    .clock(clock),
    .srst(srst),
    .q(outQ)
  );

  assign outValid = outQ.rdValid;
  assign outData = outQ.rdData;
  assign outQ.rdReady = outReady;

  sq_state_e state_reg;
  sq_state_e state_next;
  logic cmdReady_reg;
  logic [STD_W-1:0] stdMask_reg;
  logic [SET_W-1:0] operMask_reg;
  logic [SET_W-1:0] measMask_reg;
  logic [SET_W-1:0] quesMask_reg;
  logic [7:0] sre_reg;
  logic [STD_W-1:0] stdEvent_reg;
  logic [SET_W-1:0] operEvent_reg;
  logic [SET_W-1:0] measEvent_reg;
  logic [SET_W-1:0] quesEvent_reg;
  logic [7:0] statusByte_reg;
  logic opcWait_reg;
  logic opcQueryWait_reg;
  logic [FILT_BINS-1:0] errAdmit_reg;
  logic [FILT_BINS-1:0] statAdmit_reg;
  logic [EPW-1:0] errWrPtr_reg;
  logic [EPW-1:0] errRdPtr_reg;
  logic [ECW-1:0] errCount_reg;
  logic errWasEmpty_reg;
  logic [EW-1:0] errRdData;

  logic cmdFire;
  logic clearStatus;
  logic errClear;
  logic cmdPush;
  logic [15:0] cmdPushData;
  logic opcQueryPush;
  logic fifoWr;
  logic [15:0] fifoData;
  logic errPop;
  logic errAdmitted;
  logic errPush;
  logic errIsStatus;
  logic [4:0] errBin;
  logic [4:0] cmdBin;
  logic cmdIsStatus;
  logic [EW-1:0] errEntry;
  logic [EPW-1:0] errWrAddr;
  logic [ECW-1:0] errCountAfterClr;
  logic [EPW-1:0] errWrPtrAfterClr;
  logic opsDone;

  assign cmdReady = cmdReady_reg;
  assign statusByte = statusByte_reg;
  assign cmdFire = cmdValid & cmdReady_reg;
  assign clearStatus = cmdFire & (cmdOp == CMD_CLEAR_STATUS);
  assign errClear = clearStatus
                    | (cmdFire & (cmdOp == CMD_ERR_CLEAR_A))
                    | (cmdFire & (cmdOp == CMD_ERR_CLEAR_B));
  assign opsDone = ~opsPending;

  // Code classification and filter bin
  assign errIsStatus = ~errCode[15] & (errCode >= $signed(STATUS_FLOOR));
  assign errBin = {errCode[15], errCode[9:6]};
  assign cmdIsStatus = ~cmdData[15] & ($signed(cmdData) >= $signed(STATUS_FLOOR));
  assign cmdBin = {cmdData[15], cmdData[9:6]};
  assign errAdmitted = errIsStatus ? statAdmit_reg[errBin] : errAdmit_reg[errBin];

  // Immediate query responses
  always_comb begin
    cmdPush = 1'b0;
    cmdPushData = 16'h0000;
    if (cmdFire) begin
      case (cmdOp)
        CMD_STD_MASK_RD: begin
          cmdPush = 1'b1;
          cmdPushData = {8'h00, stdMask_reg};
        end
        CMD_OPER_MASK_RD: begin
          cmdPush = 1'b1;
          cmdPushData = operMask_reg;
        end
        CMD_MEAS_MASK_RD: begin
          cmdPush = 1'b1;
          cmdPushData = measMask_reg;
        end
        CMD_QUES_MASK_RD: begin
          cmdPush = 1'b1;
          cmdPushData = quesMask_reg;
        end
        CMD_SRE_RD: begin
          cmdPush = 1'b1;
          cmdPushData = {8'h00, sre_reg};
        end
        CMD_STB_RD: begin
          cmdPush = 1'b1;
          cmdPushData = {8'h00, statusByte_reg};
        end
        CMD_STD_EVENT_RD: begin
          cmdPush = 1'b1;
          cmdPushData = {8'h00, stdEvent_reg};
        end
        CMD_OPER_EVENT_RD: begin
          cmdPush = 1'b1;
          cmdPushData = operEvent_reg;
        end
        CMD_MEAS_EVENT_RD: begin
          cmdPush = 1'b1;
          cmdPushData = measEvent_reg;
        end
        CMD_QUES_EVENT_RD: begin
          cmdPush = 1'b1;
          cmdPushData = quesEvent_reg;
        end
        default: begin
          cmdPush = 1'b0;
          cmdPushData = 16'h0000;
        end
      endcase
    end
  end

  // Output queue write arbitration: error readout, then commands, then pending query
  assign opcQueryPush = opcQueryWait_reg & opsDone & (state_reg == ST_IDLE) & ~cmdPush;
  always_comb begin
    fifoWr = 1'b0;
    fifoData = 16'h0000;
    case (state_reg)
      ST_ERR_CODE: begin
        fifoWr = 1'b1;
        fifoData = errWasEmpty_reg ? CODE_NO_ERROR : errRdData[EW-1:ERR_TEXT_W];
      end
      ST_ERR_TEXT: begin
        fifoWr = 1'b1;
        fifoData = errWasEmpty_reg ? {8'h00, TEXT_NO_ERROR}
                                   : {8'h00, errRdData[ERR_TEXT_W-1:0]};
      end
      default: begin
        if (cmdPush) begin
          fifoWr = 1'b1;
          fifoData = cmdPushData;
        end else if (opcQueryPush) begin
          fifoWr = 1'b1;
          fifoData = ASCII_ONE;
        end
      end
    endcase
  end
  assign outQ.wrValid = fifoWr;
  assign outQ.wrData = fifoData;

  // Error readout sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmdFire && cmdOp == CMD_ERR_NEXT_RD) begin
          state_next = ST_ERR_CODE;
        end
      end
      ST_ERR_CODE: begin
        if (outQ.wrReady) begin
          state_next = ST_ERR_TEXT;
        end
      end
      ST_ERR_TEXT: begin
        if (outQ.wrReady) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      errWasEmpty_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (cmdFire && cmdOp == CMD_ERR_NEXT_RD) begin
        errWasEmpty_reg <= (errCount_reg == '0);
      end
    end
  end

  // Command acceptance: room for two words and no readout in flight
  always_ff @(posedge clock) begin
    if (srst) begin
      cmdReady_reg <= 1'b0;
    end else begin
      cmdReady_reg <= (state_next == ST_IDLE)
                      && ({1'b0, outQ.count} + (OCW + 1)'(fifoWr) + (OCW + 1)'(2)
                          <= (OCW + 1)'(OUT_DEPTH));
    end
  end

  // Mask registers
  always_ff @(posedge clock) begin
    if (srst || (cmdFire && cmdOp == CMD_PRESET)) begin
      stdMask_reg <= STD_MASK_RESET;
      operMask_reg <= SET_MASK_RESET;
      measMask_reg <= SET_MASK_RESET;
      quesMask_reg <= SET_MASK_RESET;
    end else if (cmdFire) begin
      case (cmdOp)
        CMD_STD_MASK_WR: stdMask_reg <= cmdData[STD_W-1:0];
        CMD_OPER_MASK_WR: operMask_reg <= cmdData;
        CMD_MEAS_MASK_WR: measMask_reg <= cmdData;
        CMD_QUES_MASK_WR: quesMask_reg <= cmdData;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      sre_reg <= SRE_RESET;
    end else if (cmdFire && cmdOp == CMD_SRE_WR) begin
      sre_reg <= cmdData[7:0];
    end
  end

  // Event registers: a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      stdEvent_reg <= '0;
      operEvent_reg <= '0;
      measEvent_reg <= '0;
      quesEvent_reg <= '0;
    end else begin
      stdEvent_reg <= ((clearStatus || (cmdFire && cmdOp == CMD_STD_EVENT_RD))
                       ? '0 : stdEvent_reg) | stdEvents
                      | (STD_W'(opcWait_reg & opsDone) << ESR_OPC);
      operEvent_reg <= ((clearStatus || (cmdFire && cmdOp == CMD_OPER_EVENT_RD))
                        ? '0 : operEvent_reg) | operEvents;
      measEvent_reg <= ((clearStatus || (cmdFire && cmdOp == CMD_MEAS_EVENT_RD))
                        ? '0 : measEvent_reg) | measEvents;
      quesEvent_reg <= ((clearStatus || (cmdFire && cmdOp == CMD_QUES_EVENT_RD))
                        ? '0 : quesEvent_reg) | quesEvents;
    end
  end

  // Pending operation-complete requests
  always_ff @(posedge clock) begin
    if (srst) begin
      opcWait_reg <= 1'b0;
      opcQueryWait_reg <= 1'b0;
    end else begin
      if (cmdFire && cmdOp == CMD_OP_DONE) begin
        opcWait_reg <= 1'b1;
      end else if (opsDone) begin
        opcWait_reg <= 1'b0;
      end
      if (cmdFire && cmdOp == CMD_OP_DONE_RD) begin
        opcQueryWait_reg <= 1'b1;
      end else if (opcQueryPush) begin
        opcQueryWait_reg <= 1'b0;
      end
    end
  end

  // Status byte
  always_ff @(posedge clock) begin
    if (srst) begin
      statusByte_reg <= 8'h00;
    end else begin
      statusByte_reg[STB_MSB] <= |(measEvent_reg & measMask_reg);
      statusByte_reg[1] <= 1'b0;
      statusByte_reg[STB_EAV] <= (errCount_reg != '0);
      statusByte_reg[STB_QSB] <= |(quesEvent_reg & quesMask_reg);
      statusByte_reg[STB_MAV] <= outQ.rdValid;
      statusByte_reg[STB_ESB] <= |(stdEvent_reg & stdMask_reg);
      statusByte_reg[STB_OSB] <= |(operEvent_reg & operMask_reg);
      statusByte_reg[STB_MSS] <= |(statusByte_reg & sre_reg & ~(8'h01 << STB_MSS));
    end
  end

  // Message filter, untouched by clear-status and preset
  always_ff @(posedge clock) begin
    if (srst) begin
      errAdmit_reg <= ERR_ADMIT_RESET;
      statAdmit_reg <= STAT_ADMIT_RESET;
    end else if (cmdFire) begin
      case (cmdOp)
        CMD_FILT_ENA_BEGIN: begin
          errAdmit_reg <= '0;
          statAdmit_reg <= '0;
        end
        CMD_FILT_ENA_ADD: begin
          if (cmdIsStatus) begin
            statAdmit_reg[cmdBin] <= 1'b1;
          end else begin
            errAdmit_reg[cmdBin] <= 1'b1;
          end
        end
        CMD_FILT_DIS: begin
          if (cmdIsStatus) begin
            statAdmit_reg[cmdBin] <= 1'b0;
          end else begin
            errAdmit_reg[cmdBin] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Error queue pointers; an entry in the clearing cycle survives the clear
  assign errPop = (state_reg == ST_ERR_TEXT) & outQ.wrReady & ~errWasEmpty_reg;
  assign errPush = errValid & errAdmitted
                   & (errClear | (errCount_reg != ECW'(ERR_DEPTH)));
  assign errEntry = (~errClear && errCount_reg == ECW'(ERR_DEPTH - 1))
                    ? {CODE_OVERFLOW, TEXT_OVERFLOW}
                    : {errCode, errText};
  assign errWrAddr = errClear ? '0 : errWrPtr_reg;
  assign errCountAfterClr = errClear ? '0 : errCount_reg - ECW'(errPop);
  assign errWrPtrAfterClr = errClear ? '0 : errWrPtr_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      errWrPtr_reg <= '0;
      errRdPtr_reg <= '0;
      errCount_reg <= '0;
    end else begin
      errCount_reg <= errCountAfterClr + ECW'(errPush);
      if (errPush) begin
        errWrPtr_reg <= (errWrPtrAfterClr == EPW'(ERR_DEPTH - 1))
                        ? '0 : errWrPtrAfterClr + 1'b1;
      end else begin
        errWrPtr_reg <= errWrPtrAfterClr;
      end
      if (errClear) begin
        errRdPtr_reg <= '0;
      end else if (errPop) begin
        errRdPtr_reg <= (errRdPtr_reg == EPW'(ERR_DEPTH - 1)) ? '0 : errRdPtr_reg + 1'b1;
      end
    end
  end

  sq_err_mem #(.W(EW), .D(ERR_DEPTH)) errMem (
    .clock(clock),
    .wrEn(errPush),
    .wrAddr(errWrAddr),
    .wrData(errEntry),
    .rdAddr(errRdPtr_reg),
    .rdData(errRdData)
  );
endmodule
`default_nettype wire

// ---- dv/sq_status_top_sva.sv ----
// Port assertions for the status and queue block
`timescale 1ns/100ps
`default_nettype none
module sq_status_top_sva import sq_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic cmdValid,
  input wire sq_cmd_e cmdOp,
  input wire logic cmdReady,
  input wire logic outValid,
  input wire logic [OUT_Q_WIDTH-1:0] outData,
  input wire logic outReady,
  input wire logic errValid,
  input wire logic [7:0] statusByte
);
  logic take;
  assign take = cmdValid && cmdReady;
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  property p_rst;
    disable iff (1'b0) srst |=> !cmdReady && !outValid && statusByte == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_spare;
    statusByte[1] == 1'b0;
  endproperty
  a_spare: assert property (p_spare) else $error("spare bit set");
  property p_mav;
    1'b1 |=> statusByte[STB_MAV] == $past(outValid);
  endproperty
  a_mav: assert property (p_mav) else $error("message bit wrong");
  property p_stb;
    take && cmdOp == CMD_STB_RD && !outValid
      |=> outValid && outData == {8'h00, $past(statusByte)};
  endproperty
  a_stb: assert property (p_stb) else $error("status byte word");
  property p_hold;
    outValid && !outReady |=> outValid && $stable(outData);
  endproperty
  a_hold: assert property (p_hold) else $error("head not held");
  property p_fell;
    $fell(outValid) |-> $past(outReady);
  endproperty
  a_fell: assert property (p_fell) else $error("pop without read");
  property p_errRdy;
    take && cmdOp == CMD_ERR_NEXT_RD |=> !cmdReady [*2];
  endproperty
  a_errRdy: assert property (p_errRdy) else $error("taken in readout");
  property p_eavClr;
    (take && cmdOp inside {CMD_CLEAR_STATUS, CMD_ERR_CLEAR_A, CMD_ERR_CLEAR_B} && !errValid
      && !$past(errValid)) ##1 !errValid [*3] |-> !statusByte[STB_EAV];
  endproperty
  a_eavClr: assert property (p_eavClr) else $error("error bit kept");
endmodule
bind sq_status_top sq_status_top_sva sq_status_top_sva_i (.clock(clock), .srst(srst),
  .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdReady(cmdReady), .outValid(outValid),
  .outData(outData), .outReady(outReady), .errValid(errValid), .statusByte(statusByte));
`default_nettype wire

// ---- dv/sq_host.sv ----
// Host side model that reads the output queue, promptly or slowly
`timescale 1ns/100ps
`default_nettype none
module sq_host import sq_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic hold,
  input wire logic slow,
  input wire logic outValid,
  input wire logic [OUT_Q_WIDTH-1:0] outData,
  output logic outReady,
  output logic popValid,
  output logic [OUT_Q_WIDTH-1:0] popData
);
  logic [1:0] phase;
  always_ff @(posedge clock) begin
    phase <= srst ? 2'h0 : phase + 2'h1;
    outReady <= !srst && !hold && (!slow || phase == 2'h3);
    popValid <= !srst && outValid && outReady;
    popData <= outData;
  end
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the status and queue block
`timescale 1ns/100ps
`default_nettype none
module tb import sq_pkg::*; ;
  logic clock = 1'b0, srst = 1'b1, cmdValid = 1'b0, opsPending = 1'b0, errValid = 1'b0;
  logic hold = 1'b0, slow = 1'b0, cmdReady, outValid, outReady, popValid;
  sq_cmd_e cmdOp = CMD_NOP;
  logic [15:0] cmdData = 16'h0000, outData, popData, v;
  logic signed [15:0] errCode = 16'sh0000;
  logic [7:0] stdEvents = 8'h00, errText = 8'h00, statusByte;
  logic [15:0] operEvents = 16'h0000;
  wire [15:0] measEvents = operEvents, quesEvents = operEvents;
  logic [15:0] expQ[$];
  logic [15:0] mv[5];
  logic [15:0] wid[5] = '{16'h00ff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff};
  sq_cmd_e wrOp[5] = '{CMD_STD_MASK_WR, CMD_OPER_MASK_WR, CMD_MEAS_MASK_WR, CMD_QUES_MASK_WR,
    CMD_SRE_WR};
  sq_cmd_e rdOp[5] = '{CMD_STD_MASK_RD, CMD_OPER_MASK_RD, CMD_MEAS_MASK_RD, CMD_QUES_MASK_RD,
    CMD_SRE_RD};
  sq_cmd_e clrOp[4] = '{CMD_ERR_CLEAR_A, CMD_ERR_CLEAR_B, CMD_CLEAR_STATUS, CMD_PRESET};
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  integer seed = 32'habcd;

  initial begin
    forever #12.5 clock = ~clock;
  end

  sq_status_top sq_status_top_i (.clock(clock), .srst(srst), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdData(cmdData), .cmdReady(cmdReady), .outValid(outValid),
    .outData(outData), .outReady(outReady), .stdEvents(stdEvents), .operEvents(operEvents),
    .measEvents(measEvents), .quesEvents(quesEvents), .opsPending(opsPending),
    .errValid(errValid), .errCode(errCode), .errText(errText), .statusByte(statusByte));
  sq_host sq_host_i (.clock(clock), .srst(srst), .hold(hold), .slow(slow),
    .outValid(outValid), .outData(outData), .outReady(outReady), .popValid(popValid),
    .popData(popData));

  task automatic fail(input string m);
    n_mismatch++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail($sformatf("got %h want %h", got, exp));
    end
  endtask
  function automatic logic [15:0] sums();
    return {12'h000, statusByte[5], statusByte[7], statusByte[0], statusByte[3]};
  endfunction
  task automatic sb(input int b, input logic e);
    chk({15'h0000, statusByte[b]}, {15'h0000, e});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic cmd(input sq_cmd_e op, input logic [15:0] d = 16'h0000);
    int t = 0;
    cmdOp <= op;
    cmdData <= d;
    cmdValid <= 1'b1;
    do begin
      @(posedge clock);
      t++;
    end while (cmdReady !== 1'b1 && t < 100);
    if (t == 100) begin
      fail("command stuck");
    end
    cmdValid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic q(input sq_cmd_e op, input logic [15:0] e);
    expQ.push_back(e);
    cmd(op);
  endtask
  task automatic rdErr(input logic [15:0] c, input logic [7:0] t);
    expQ.push_back(c);
    q(CMD_ERR_NEXT_RD, {8'h00, t});
  endtask
  task automatic err(input logic [15:0] c, input logic [7:0] t);
    errCode <= c;
    errText <= t;
    errValid <= 1'b1;
    @(posedge clock);
    errValid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic ev(input logic [7:0] s, input logic [15:0] e);
    stdEvents <= s;
    operEvents <= e;
    @(posedge clock);
    stdEvents <= 8'h00;
    operEvents <= 16'h0000;
    idle(4);
  endtask
  task automatic done(input string s);
    idle(30);
    if (expQ.size() != 0) begin
      fail("words missing");
    end
    $display("Test %s done", s);
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    if (popValid === 1'b1) begin
      if (expQ.size() == 0) begin
        fail("extra word");
      end else begin
        chk(popData, expQ.pop_front());
      end
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    idle(4);
    q(CMD_STB_RD, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      q(rdOp[i], 16'h0000);
    end
    done("reset values");
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 3; j++) begin
        v = (j == 0) ? 16'hffff : (j == 1) ? 16'($random(seed)) : 16'h0000;
        v = v & wid[i];
        cmd(wrOp[i], v);
        q(rdOp[i], v);
      end
      mv[i] = (16'($random(seed)) | 16'h0001) & wid[i];
      cmd(wrOp[i], mv[i]);
    end
    cmd(CMD_CLEAR_STATUS);
    for (int i = 0; i < 5; i++) begin
      q(rdOp[i], mv[i]);
    end
    cmd(CMD_PRESET);
    for (int i = 0; i < 5; i++) begin
      q(rdOp[i], (i == 4) ? mv[i] : 16'h0000);
    end
    done("masks");
    ev(8'h04, 16'h0001);
    chk(sums(), 16'h0000);
    cmd(CMD_STD_MASK_WR, 16'h0004);
    cmd(CMD_OPER_MASK_WR, 16'h0001);
    cmd(CMD_MEAS_MASK_WR, 16'h0001);
    cmd(CMD_QUES_MASK_WR, 16'h0001);
    idle(4);
    chk(sums(), 16'h000f);
    sb(STB_MSS, 1'b1);
    q(CMD_STD_EVENT_RD, 16'h0004);
    q(CMD_OPER_EVENT_RD, 16'h0001);
    q(CMD_MEAS_EVENT_RD, 16'h0001);
    q(CMD_QUES_EVENT_RD, 16'h0001);
    idle(4);
    chk(sums(), 16'h0000);
    q(CMD_STD_EVENT_RD, 16'h0000);
    done("summary");
    hold <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      q(CMD_SRE_RD, mv[4]);
    end
    idle(2);
    chk({15'h0000, cmdReady}, 16'h0000);
    sb(STB_MAV, 1'b1);
    hold <= 1'b0;
    slow <= 1'b1;
    q(CMD_SRE_RD, mv[4]);
    idle(40);
    sb(STB_MAV, 1'b0);
    slow <= 1'b0;
    done("output queue");
    for (int k = 1; k <= 12; k++) begin
      err(16'hff9c - 16'(k), 8'(k));
    end
    idle(4);
    sb(STB_EAV, 1'b1);
    for (int k = 1; k <= 9; k++) begin
      rdErr(16'hff9c - 16'(k), 8'(k));
    end
    rdErr(16'h015e, 8'h01);
    rdErr(16'h0000, 8'h00);
    idle(4);
    sb(STB_EAV, 1'b0);
    done("error queue");
    for (int i = 0; i < 4; i++) begin
      err(16'hff00, 8'(i));
      err(16'h0007, 8'(i));
      ev(8'h10, 16'h0000);
      cmd(clrOp[i]);
      idle(4);
      if (i == 3) begin
        rdErr(16'hff00, 8'(i));
        rdErr(16'h0007, 8'(i));
        q(CMD_STD_EVENT_RD, 16'h0010);
      end else begin
        rdErr(16'h0000, 8'h00);
        q(CMD_STD_EVENT_RD, (i == 2) ? 16'h0000 : 16'h0010);
      end
    end
    done("clears");
    err(16'h0384, 8'h05);
    idle(4);
    rdErr(16'h0000, 8'h00);
    cmd(CMD_FILT_ENA_BEGIN);
    cmd(CMD_CLEAR_STATUS);
    cmd(CMD_PRESET);
    err(16'hff9c, 8'h01);
    idle(4);
    rdErr(16'h0000, 8'h00);
    cmd(CMD_FILT_ENA_ADD, 16'h0384);
    cmd(CMD_FILT_ENA_ADD, 16'h0444);
    err(16'hff9c, 8'h01);
    err(16'h0384, 8'h02);
    idle(4);
    rdErr(16'h0384, 8'h02);
    rdErr(16'h0000, 8'h00);
    cmd(CMD_FILT_DIS, 16'h0384);
    err(16'h0384, 8'h03);
    err(16'h0444, 8'h04);
    idle(4);
    rdErr(16'h0444, 8'h04);
    rdErr(16'h0000, 8'h00);
    done("filter");
    opsPending <= 1'b1;
    cmd(CMD_OP_DONE_RD);
    idle(6);
    sb(STB_MAV, 1'b0);
    expQ.push_back(16'h0031);
    opsPending <= 1'b0;
    idle(6);
    opsPending <= 1'b1;
    cmd(CMD_OP_DONE);
    idle(4);
    q(CMD_STD_EVENT_RD, 16'h0000);
    opsPending <= 1'b0;
    idle(4);
    q(CMD_STD_EVENT_RD, 16'h0001);
    done("operation complete");
    report_and_stop();
  end
endmodule
`default_nettype wire
